// ---- logic/msc_pkg.sv ----
// Purpose: shared constants for the multiplexed conversion control
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   pulse widths are the host's to meet; counts derive from ns
package msc_pkg;
	localparam int CLK_PERIOD_NS   = 25;
	localparam int RESULT_BITS     = 8;
	localparam int CHAN_BITS       = 3;
	localparam int CHAN_COUNT      = 8;
	localparam int BIT_SETTLE_CYC  = 4;
	localparam int EOC_DROP_MAX    = 8;
	localparam int START_MIN_NS    = 200;
	localparam int ALE_MIN_NS      = 200;
	localparam int MUX_SETTLE_NS   = 2500;
	localparam int START_MIN_CYC   =
		(START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALE_MIN_CYC     =
		(ALE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MUX_SETTLE_CYC  =
		(MUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [2:0] CHAN_RST   = 3'h0;
	localparam logic [2:0] TOP_BIT    = 3'h7;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_HOLD  = 5'b00010,
		ST_TRIAL = 5'b00100,
		ST_LOAD  = 5'b01000,
		ST_DONE  = 5'b10000
	} msc_state_t;
endpackage

// ---- logic/msc_chan_latch.sv ----
// Purpose: channel address latch and one-of-eight input decoder
// Assumes: select lines and strobe are synchronous to clk
// Notes:   selection changes only on a rising strobe
`timescale 1ns/1ps
`default_nettype none
module msc_chan_latch
	import msc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [CHAN_BITS-1:0]  chanSel,
	input  wire logic                  addrLatch,
	output var  logic [CHAN_BITS-1:0]  chanCode_reg,
	output var  logic [CHAN_COUNT-1:0] muxSelect_reg
);
	logic                  latchPrev_reg;
	logic                  latchRise;
	logic [CHAN_BITS-1:0]  chanCode_next;
	logic [CHAN_COUNT-1:0] muxSelect_next;

	function automatic logic [CHAN_COUNT-1:0] decode(
		input logic [CHAN_BITS-1:0] code);
		decode = CHAN_COUNT'(1) << code;
	endfunction

	assign latchRise      = addrLatch & ~latchPrev_reg;
	assign chanCode_next  = latchRise ? chanSel : chanCode_reg;
	assign muxSelect_next = decode(chanCode_next);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			latchPrev_reg <= 1'b0;
			chanCode_reg  <= CHAN_RST;
			muxSelect_reg <= CHAN_COUNT'(1);
		end
		else
		begin
			latchPrev_reg <= addrLatch;
			chanCode_reg  <= chanCode_next;
			muxSelect_reg <= muxSelect_next;
		end
	end
endmodule
`default_nettype wire

// ---- logic/msc_approx_reg.sv ----
// Purpose: successive approximation register, one flop per bit
// Assumes: set and decide indices come from the control sequencer
// Notes:   clear outranks decide, decide outranks set on a bit
`timescale 1ns/1ps
`default_nettype none
module msc_approx_reg
	import msc_pkg::*;
#(
	parameter int WIDTH = RESULT_BITS
)
(
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     clearAll,
	input  wire logic                     setEn,
	input  wire logic [$clog2(WIDTH)-1:0] setIdx,
	input  wire logic                     decideEn,
	input  wire logic [$clog2(WIDTH)-1:0] decideIdx,
	input  wire logic                     keepBit,
	output var  logic [WIDTH-1:0]         approx_reg
);
	localparam int IDX_W = $clog2(WIDTH);

	logic [WIDTH-1:0] approx_next;

	generate
		if (WIDTH < 2)
		begin : g_bad
			$error("approximation width must be at least 2");
		end
		for (genvar i = 0; i < WIDTH; i++)
		begin : g_bit
			// a bit tried and found above the input is dropped
			assign approx_next[i] = clearAll ? 1'b0 :
				(decideEn && decideIdx == IDX_W'(i) && !keepBit) ? 1'b0 :
				(setEn && setIdx == IDX_W'(i)) ? 1'b1 : approx_reg[i];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
			approx_reg <= '0;
		else
			approx_reg <= approx_next;
	end
endmodule
`default_nettype wire

// ---- logic/msc_conv_ctrl.sv ----
// Purpose: control of an 8-bit successive approximation converter
// Assumes: compHigh is the comparator: input at or above trial level
// Notes:   data pins are split into value and enable, no tristate here
`timescale 1ns/1ps
`default_nettype none
module msc_conv_ctrl
	import msc_pkg::*;
#(
	parameter int SETTLE = BIT_SETTLE_CYC
)
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [CHAN_BITS-1:0]   chanSel,
	input  wire logic                   addrLatch,
	input  wire logic                   convStart,
	input  wire logic                   outEnable,
	input  wire logic                   compHigh,
	output var  logic [CHAN_COUNT-1:0]  muxSelect,
	output var  logic [RESULT_BITS-1:0] trialCode,
	output var  logic [RESULT_BITS-1:0] dataOut,
	output var  logic                   dataOutEn,
	output var  logic                   endOfConv
);
	localparam int CNT_W = (SETTLE > 1) ? $clog2(SETTLE) : 1;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE - 1);

	generate
		if (SETTLE < 1)
		begin : g_bad
			$error("settle count must be at least 1");
		end
	endgenerate

	msc_state_t             state_reg;
	msc_state_t             state_next;
	logic                   startPrev_reg;
	logic [2:0]             bitIdx_reg;
	logic [2:0]             bitIdx_next;
	logic [CNT_W-1:0]       settle_reg;
	logic [CNT_W-1:0]       settle_next;
	logic [RESULT_BITS-1:0] result_reg;
	logic [RESULT_BITS-1:0] result_next;
	logic                   eoc_reg;
	logic                   eoc_next;
	logic                   oe_reg;
	logic [CHAN_BITS-1:0]   chanCode;
	logic                   startRise;
	logic                   startFall;
	logic                   stepDone;
	logic                   lastBit;
	logic                   clearAll;
	logic                   setEn;
	logic [2:0]             setIdx;
	logic                   decideEn;

	msc_chan_latch u_chan (
		.clk           (clk),
		.rst           (rst),
		.chanSel       (chanSel),
		.addrLatch     (addrLatch),
		.chanCode_reg  (chanCode),
		.muxSelect_reg (muxSelect)
	);

	// start edges, inputs already synchronous
	assign startRise = convStart & ~startPrev_reg;
	assign startFall = ~convStart & startPrev_reg;
	assign stepDone  = (state_reg == ST_TRIAL) && (settle_reg == CNT_LAST);
	assign lastBit   = (bitIdx_reg == 3'h0);

	// a new rising start overrides every state
	assign clearAll = startRise;
	assign decideEn = stepDone && !startRise;
	assign setEn    = !startRise &&
		((state_reg == ST_HOLD && startFall) || (decideEn && !lastBit));
	assign setIdx   = (state_reg == ST_HOLD) ? TOP_BIT
		: bitIdx_reg - 3'h1;

	msc_approx_reg #(
		.WIDTH (RESULT_BITS)
	) u_sar (
		.clk        (clk),
		.rst        (rst),
		.clearAll   (clearAll),
		.setEn      (setEn),
		.setIdx     (setIdx),
		.decideEn   (decideEn),
		.decideIdx  (bitIdx_reg),
		.keepBit    (compHigh),
		.approx_reg (trialCode)
	);

	always_comb
	begin
		state_next  = state_reg;
		bitIdx_next = bitIdx_reg;
		settle_next = settle_reg;
		if (startRise)
			state_next = ST_HOLD;
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					state_next = ST_IDLE;
				ST_HOLD:
				begin
					if (startFall)
					begin
						state_next  = ST_TRIAL;
						bitIdx_next = TOP_BIT;
						settle_next = '0;
					end
				end
				ST_TRIAL:
				begin
					if (stepDone)
					begin
						settle_next = '0;
						if (lastBit)
							state_next = ST_LOAD;
						else
							bitIdx_next = bitIdx_reg - 3'h1;
					end
					else
						settle_next = settle_reg + CNT_W'(1);
				end
				ST_LOAD:
					state_next = ST_DONE;
				ST_DONE:
					state_next = ST_DONE;
			endcase
		end
	end

	// result loads on leaving LOAD, flag rises one edge later
	assign result_next = (state_reg == ST_LOAD && !startRise)
		? trialCode : result_reg;
	assign eoc_next = (state_reg == ST_DONE) && !startRise;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg     <= ST_IDLE;
			startPrev_reg <= 1'b0;
			bitIdx_reg    <= TOP_BIT;
			settle_reg    <= '0;
			result_reg    <= RESULT_RST;
			eoc_reg       <= 1'b0;
			oe_reg        <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			startPrev_reg <= convStart;
			bitIdx_reg    <= bitIdx_next;
			settle_reg    <= settle_next;
			result_reg    <= result_next;
			eoc_reg       <= eoc_next;
			oe_reg        <= outEnable;
		end
	end

	assign dataOut   = result_reg;
	assign dataOutEn = oe_reg;
	assign endOfConv = eoc_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_chanLatch;
		(addrLatch && !$past(addrLatch)) |=> ##1 chanCode == $past(chanSel, 2);
	endproperty
	a_chanLatch: assert property (p_chanLatch)
		else $error("channel code not taken on strobe rise");

	property p_chanHold;
		!(addrLatch && !$past(addrLatch)) |=> $stable(chanCode);
	endproperty
	a_chanHold: assert property (p_chanHold)
		else $error("channel code changed without strobe rise");

	property p_muxDecode;
		$onehot(muxSelect) && muxSelect[chanCode];
	endproperty
	a_muxDecode: assert property (p_muxDecode)
		else $error("input select does not match channel code");

	property p_sarClear;
		startRise |=> trialCode == '0 && state_reg == ST_HOLD;
	endproperty
	a_sarClear: assert property (p_sarClear)
		else $error("approximation register not cleared on start rise");

	property p_beginFall;
		(state_reg == ST_HOLD && startFall) |=> trialCode == 8'h80
			##SETTLE state_reg == ST_TRIAL && bitIdx_reg == 3'h6;
	endproperty
	a_beginFall: assert property (p_beginFall)
		else $error("conversion did not begin on start fall");

	property p_restart;
		(startRise && state_reg != ST_IDLE) |=> state_reg == ST_HOLD;
	endproperty
	a_restart: assert property (p_restart)
		else $error("running conversion not abandoned on new start");

	property p_eocDrop;
		startRise |-> ##[1:8] !endOfConv;
	endproperty
	a_eocDrop: assert property (p_eocDrop)
		else $error("end of conversion late to fall after start");

	property p_loadFirst;
		$rose(endOfConv) |-> $past(state_reg == ST_LOAD, 2)
			&& dataOut == $past(trialCode, 2) && $stable(dataOut);
	endproperty
	a_loadFirst: assert property (p_loadFirst)
		else $error("result not loaded one clock before flag");

	property p_oeFollow;
		1'b1 |=> dataOutEn == $past(outEnable)
			&& (dataOut == $past(dataOut) || $past(state_reg == ST_LOAD));
	endproperty
	a_oeFollow: assert property (p_oeFollow)
		else $error("output enable or data does not follow");

	property p_eocHold;
		(endOfConv && !startRise) |=> endOfConv;
	endproperty
	a_eocHold: assert property (p_eocHold)
		else $error("end of conversion dropped without start");

	property p_eocLowBusy;
		(state_reg == ST_TRIAL || state_reg == ST_HOLD) |-> !endOfConv;
	endproperty
	a_eocLowBusy: assert property (p_eocLowBusy)
		else $error("end of conversion high during conversion");

	property p_bitStep;
		(decideEn && !lastBit) |=> bitIdx_reg == $past(bitIdx_reg) - 3'h1
			&& trialCode[bitIdx_reg];
	endproperty
	a_bitStep: assert property (p_bitStep)
		else $error("next lower bit not tried after a decision");

	property p_keepBit;
		decideEn |=> trialCode[$past(bitIdx_reg)] == $past(compHigh);
	endproperty
	a_keepBit: assert property (p_keepBit)
		else $error("decided bit does not follow the comparator");

	property p_lowerClear;
		state_reg == ST_TRIAL
			|-> (trialCode & ((8'h01 << bitIdx_reg) - 8'h01)) == 8'h00;
	endproperty
	a_lowerClear: assert property (p_lowerClear)
		else $error("bits below the tried bit are not clear");

	property p_holdWait;
		(state_reg == ST_HOLD && convStart) |=> state_reg == ST_HOLD;
	endproperty
	a_holdWait: assert property (p_holdWait)
		else $error("conversion began while start still high");

	property p_holdClear;
		state_reg == ST_HOLD |-> trialCode == 8'h00;
	endproperty
	a_holdClear: assert property (p_holdClear)
		else $error("approximation register not clear while start high");

	property p_loadDone;
		(state_reg == ST_LOAD && !startRise) |=> state_reg == ST_DONE
			&& dataOut == $past(trialCode);
	endproperty
	a_loadDone: assert property (p_loadDone)
		else $error("result register not loaded from final code");

	property p_eocRise;
		$rose(endOfConv) |-> state_reg == ST_DONE;
	endproperty
	a_eocRise: assert property (p_eocRise)
		else $error("end of conversion rose before the last bit");

	property p_eocIdle;
		state_reg == ST_IDLE |-> !endOfConv;
	endproperty
	a_eocIdle: assert property (p_eocIdle)
		else $error("end of conversion high with no conversion run");
endmodule
`default_nettype wire

// ---- tb/msc_host_model.sv ----
// Purpose: host pin driver and analog input model for conversion control
// Assumes: pins change on falling clk; compHigh follows selected level
// Notes:   released address lines show the inverse of the last code
`timescale 1ns/1ps
`default_nettype none
module msc_host_model
	import msc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic [CHAN_COUNT-1:0]  muxSelect,
	input  wire logic [RESULT_BITS-1:0] trialCode,
	output var  logic [CHAN_BITS-1:0]   chanSel,
	output var  logic                   addrLatch,
	output var  logic                   hostStart,
	output var  logic                   outEnable,
	output var  logic                   compHigh
);
	logic [RESULT_BITS-1:0] level [CHAN_COUNT];
	logic [RESULT_BITS-1:0] selLevel;

	initial
	begin
		chanSel = 3'h0;
		addrLatch = 1'b0;
		hostStart = 1'b0;
		outEnable = 1'b0;
		foreach (level[i]) level[i] = 8'h00;
	end

	always_comb
	begin
		selLevel = 8'h00;
		for (int i = 0; i < CHAN_COUNT; i++)
			if (muxSelect[i])
				selLevel = level[i];
	end
	assign compHigh = selLevel >= trialCode;

	task automatic latch(input logic [CHAN_BITS-1:0] c);
		@(negedge clk) chanSel = c;
		addrLatch = 1'b1;
		repeat (ALE_MIN_CYC) @(negedge clk);
		addrLatch = 1'b0;
		chanSel = ~c;
		repeat (MUX_SETTLE_CYC) @(negedge clk);
	endtask

	// one external pulse also kicks off free running
	task automatic start();
		@(negedge clk) hostStart = 1'b1;
		repeat (START_MIN_CYC) @(negedge clk);
		hostStart = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/test_mux_sar_conversion_control.sv ----
// Purpose: self-checking bench for the conversion control block
// Assumes: SETTLE of 1 keeps conversions short
// Notes:   data pins resolved here from value and enable
`timescale 1ns/1ps
`default_nettype none
module test_mux_sar_conversion_control
	import msc_pkg::*;
;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   freeRun = 1'b0;
	logic [CHAN_BITS-1:0]   chanSel;
	logic                   addrLatch, hostStart, outEnable, compHigh;
	logic                   convStart, dataOutEn, endOfConv;
	logic [CHAN_COUNT-1:0]  muxSelect;
	logic [RESULT_BITS-1:0] trialCode, dataOut;
	wire  [RESULT_BITS-1:0] dataBus = dataOutEn ? dataOut : 8'hzz;
	int                     fails = 0;
	int                     checks = 0;
	localparam int          TB_SETTLE = 1;
	// negedges from start release to flag: one per bit, fall, load, flag
	localparam int          CONV_NEG = RESULT_BITS * TB_SETTLE + 3;

	always #12.5 clk = ~clk;
	assign convStart = freeRun ? (endOfConv | hostStart) : hostStart;

	msc_conv_ctrl #(.SETTLE(TB_SETTLE)) DUT (.clk(clk), .rst(rst),
		.chanSel(chanSel), .addrLatch(addrLatch), .convStart(convStart),
		.outEnable(outEnable), .compHigh(compHigh),
		.muxSelect(muxSelect), .trialCode(trialCode), .dataOut(dataOut),
		.dataOutEn(dataOutEn), .endOfConv(endOfConv));
	msc_host_model hostM (.clk(clk), .muxSelect(muxSelect),
		.trialCode(trialCode), .chanSel(chanSel), .addrLatch(addrLatch),
		.hostStart(hostStart), .outEnable(outEnable), .compHigh(compHigh));

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic test_channels();
		for (int c = 0; c < CHAN_COUNT; c++)
		begin
			hostM.latch(3'(c));
			check("muxSelect", muxSelect, 8'h01 << c);
		end
	endtask

	// start, observe eoc drop, wait for result; prev holds data before eoc
	task automatic run(input logic [7:0] v);
		logic [7:0] prev;
		int n;
		hostM.start();
		check("eocLow", 8'(endOfConv), 8'h00);
		check("trialClr", trialCode, 8'h00);
		n = 0;
		prev = dataOut;
		while (endOfConv !== 1'b1 && n < 40)
		begin
			prev = dataOut;
			@(negedge clk) n++;
		end
		check("convLen", 8'(n), 8'(CONV_NEG));
		check("dataEarly", prev, v);
	endtask

	task automatic convert(input logic [7:0] v, input logic [2:0] c);
		hostM.level[c] = v;
		hostM.latch(c);
		run(v);
	endtask

	task automatic test_levels();
		convert(8'h00, 3'h0);
		convert(8'hff, 3'h7);
		convert(8'h5a, 3'h2);
		convert(8'ha5, 3'h5);
	endtask

	task automatic test_abort();
		hostM.level[3] = 8'h3c;
		hostM.latch(3'h3);
		hostM.start();
		repeat (4) @(negedge clk);
		check("abortBusy", 8'(endOfConv), 8'h00);
		hostM.level[3] = 8'hc3;
		run(8'hc3);
	endtask

	task automatic test_output();
		check("busIdle", dataBus, 8'hzz);
		@(negedge clk) hostM.outEnable = 1'b1;
		@(negedge clk) check("busDrive", dataBus, 8'hc3);
		hostM.outEnable = 1'b0;
		@(negedge clk) check("busFloat", dataBus, 8'hzz);
	endtask

	// one conversion every bit count plus four clocks once fed back
	task automatic test_free_run();
		int rises;
		logic seenEoc;
		rises = 0;
		seenEoc = 1'b0;
		hostM.level[3] = 8'h81;
		freeRun = 1'b1;
		hostM.start();
		repeat (54)
		begin
			@(negedge clk);
			if (endOfConv === 1'b1 && !seenEoc)
				rises++;
			seenEoc = (endOfConv === 1'b1);
		end
		check("freeRises", 8'(rises), 8'h04);
		check("freeData", dataOut, 8'h81);
		@(negedge clk) freeRun = 1'b0;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	initial
	begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		check("rstMux", muxSelect, 8'h01);
		check("rstEoc", 8'(endOfConv), 8'h00);
		test_channels();
		test_levels();
		test_abort();
		test_output();
		test_free_run();
		report_and_stop();
	end
endmodule
`default_nettype wire
